// >>> rtl/msc_pkg.sv
// register map, field layout and frame limits of the mac statistics slice
// assumes a 32-bit apb with byte addresses and one word per register
package msc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_TYPE_ID = 8'h00;
  localparam logic [7:0] OFF_USER_IO = 8'h04;
  localparam logic [7:0] OFF_PAUSE_RX = 8'h08;
  localparam logic [7:0] OFF_TX_GOOD = 8'h0c;
  localparam logic [7:0] OFF_ONE_COLL = 8'h10;
  localparam logic [7:0] OFF_MANY_COLL = 8'h14;
  localparam logic [7:0] OFF_RX_GOOD = 8'h18;
  localparam logic [7:0] OFF_CRC_ERR = 8'h1c;
  localparam logic [7:0] OFF_ALIGN_ERR = 8'h20;
  // counter widths
  localparam int PAUSE_W = 16;
  localparam int TX_GOOD_W = 24;
  localparam int ONE_COLL_W = 16;
  localparam int MANY_COLL_W = 16;
  localparam int RX_GOOD_W = 24;
  localparam int CRC_ERR_W = 8;
  localparam int ALIGN_ERR_W = 8;
  // type id field
  localparam int TYPE_ID_W = 16;
  localparam logic [15:0] TYPE_ID_RST = 16'h0000;
  // user io fields
  localparam int USER_IO_W = 2;
  localparam int USER_IO_RMII_BIT = 0;
  localparam int USER_IO_CLK_GATE_BIT = 1;
  localparam logic [1:0] USER_IO_RST = 2'h0;
  // frame length limits in bytes
  localparam int LEN_W = 11;
  localparam logic [10:0] LEN_MIN = 11'h040;
  localparam logic [10:0] LEN_MAX = 11'h5ee;
  localparam logic [10:0] LEN_MAX_BIG = 11'h600;
  // collision counts for the transmit tallies
  localparam int COLL_W = 5;
  localparam logic [4:0] COLL_ONE = 5'h01;
  localparam logic [4:0] COLL_MANY_MIN = 5'h02;
  localparam logic [4:0] COLL_MANY_MAX = 5'h0f;
endpackage : msc_pkg

// >>> rtl/msc_stats.sv
// statistics counters, user io and type id registers of an ethernet mac
// assumes frame events are one-cycle pulses synchronous to pclk
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// one saturating clear-on-read counter
module msc_sat_counter #(
  parameter int W = 8
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic srst,
  // control
  input wire logic inc,
  input wire logic rd_clr,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  // value
  output logic [W-1:0] value
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire at_max = &cnt_q;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

  // read clears, but an event in the same cycle survives as one
  assign cnt_d = rd_clr ? (inc ? one : '0) :
                 wr ? wdata :
                 (inc && !at_max) ? cnt_q + one : cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign value = cnt_q;
endmodule // msc_sat_counter

module msc_stats (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msc_pkg::ADDR_W-1:0] paddr,
  input wire logic [msc_pkg::DATA_W-1:0] pwdata,
  output logic [msc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // mac control and configuration
  input wire logic stats_srst,
  input wire logic rx_enable,
  input wire logic stats_write_enable,
  input wire logic big_frame_enable,
  // receive frame report
  input wire logic rx_frame_done,
  input wire logic [msc_pkg::LEN_W-1:0] rx_frame_len,
  input wire logic rx_whole_bytes,
  input wire logic rx_crc_bad,
  input wire logic rx_symbol_err,
  input wire logic rx_addr_match,
  input wire logic rx_copied,
  input wire logic rx_is_pause,
  // transmit frame report
  input wire logic tx_frame_done,
  input wire logic tx_underrun,
  input wire logic tx_retry_exceeded,
  input wire logic [msc_pkg::COLL_W-1:0] tx_collisions,
  // configuration outputs
  output logic rmii_mode,
  output logic xcvr_clock_gate,
  output logic [msc_pkg::TYPE_ID_W-1:0] type_id_value
);
  logic [msc_pkg::TYPE_ID_W-1:0] type_id_q;
  logic [msc_pkg::USER_IO_W-1:0] uio_q;
  logic [msc_pkg::DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [msc_pkg::PAUSE_W-1:0] pause_cnt;
  logic [msc_pkg::TX_GOOD_W-1:0] tx_good_cnt;
  logic [msc_pkg::ONE_COLL_W-1:0] one_coll_cnt;
  logic [msc_pkg::MANY_COLL_W-1:0] many_coll_cnt;
  logic [msc_pkg::RX_GOOD_W-1:0] rx_good_cnt;
  logic [msc_pkg::CRC_ERR_W-1:0] crc_cnt;
  logic [msc_pkg::ALIGN_ERR_W-1:0] align_cnt;

  // bus phases: read effect and data capture at the end of setup
  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire rd_setup = setup && !pwrite;
  wire wr_access = access && pwrite;

  // address decode
  wire a_type_id = paddr == msc_pkg::OFF_TYPE_ID;
  wire a_uio = paddr == msc_pkg::OFF_USER_IO;
  wire a_pause = paddr == msc_pkg::OFF_PAUSE_RX;
  wire a_txg = paddr == msc_pkg::OFF_TX_GOOD;
  wire a_one = paddr == msc_pkg::OFF_ONE_COLL;
  wire a_many = paddr == msc_pkg::OFF_MANY_COLL;
  wire a_rxg = paddr == msc_pkg::OFF_RX_GOOD;
  wire a_crc = paddr == msc_pkg::OFF_CRC_ERR;
  wire a_aln = paddr == msc_pkg::OFF_ALIGN_ERR;
  wire a_cnt = a_pause | a_txg | a_one | a_many | a_rxg | a_crc | a_aln;
  wire mapped = a_type_id | a_uio | a_cnt;
  wire cnt_wr = wr_access && stats_write_enable;

  // frame qualification
  wire [msc_pkg::LEN_W-1:0] len_max = big_frame_enable ? msc_pkg::LEN_MAX_BIG
                                                        : msc_pkg::LEN_MAX;
  wire len_ok = rx_frame_len >= msc_pkg::LEN_MIN && rx_frame_len <= len_max;
  wire rx_ev = rx_frame_done && rx_enable;
  wire rx_good = len_ok && rx_whole_bytes && !rx_crc_bad && !rx_symbol_err;
  wire rx_err = rx_ev && len_ok && (rx_crc_bad || rx_symbol_err);
  wire inc_pause = rx_ev && rx_good && rx_is_pause;
  wire inc_rxg = rx_ev && rx_good && rx_addr_match && rx_copied;
  wire inc_crc = rx_err && rx_whole_bytes;
  wire inc_aln = rx_err && !rx_whole_bytes;
  wire tx_ok = tx_frame_done && !tx_underrun && !tx_retry_exceeded;
  wire inc_txg = tx_ok;
  wire inc_one = tx_ok && tx_collisions == msc_pkg::COLL_ONE;
  wire inc_many = tx_ok && tx_collisions >= msc_pkg::COLL_MANY_MIN
                  && tx_collisions <= msc_pkg::COLL_MANY_MAX;

  msc_sat_counter #(.W(msc_pkg::PAUSE_W)) u_pause (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_pause),
    .rd_clr(rd_setup && a_pause), .wr(cnt_wr && a_pause),
    .wdata(pwdata[msc_pkg::PAUSE_W-1:0]), .value(pause_cnt)
  );
  msc_sat_counter #(.W(msc_pkg::TX_GOOD_W)) u_txg (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_txg),
    .rd_clr(rd_setup && a_txg), .wr(cnt_wr && a_txg),
    .wdata(pwdata[msc_pkg::TX_GOOD_W-1:0]), .value(tx_good_cnt)
  );
  msc_sat_counter #(.W(msc_pkg::ONE_COLL_W)) u_one (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_one),
    .rd_clr(rd_setup && a_one), .wr(cnt_wr && a_one),
    .wdata(pwdata[msc_pkg::ONE_COLL_W-1:0]), .value(one_coll_cnt)
  );
  msc_sat_counter #(.W(msc_pkg::MANY_COLL_W)) u_many (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_many),
    .rd_clr(rd_setup && a_many), .wr(cnt_wr && a_many),
    .wdata(pwdata[msc_pkg::MANY_COLL_W-1:0]), .value(many_coll_cnt)
  );
  msc_sat_counter #(.W(msc_pkg::RX_GOOD_W)) u_rxg (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_rxg),
    .rd_clr(rd_setup && a_rxg), .wr(cnt_wr && a_rxg),
    .wdata(pwdata[msc_pkg::RX_GOOD_W-1:0]), .value(rx_good_cnt)
  );
  msc_sat_counter #(.W(msc_pkg::CRC_ERR_W)) u_crc (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_crc),
    .rd_clr(rd_setup && a_crc), .wr(cnt_wr && a_crc),
    .wdata(pwdata[msc_pkg::CRC_ERR_W-1:0]), .value(crc_cnt)
  );
  msc_sat_counter #(.W(msc_pkg::ALIGN_ERR_W)) u_aln (
    .pclk(pclk), .presetn(presetn), .srst(stats_srst), .inc(inc_aln),
    .rd_clr(rd_setup && a_aln), .wr(cnt_wr && a_aln),
    .wdata(pwdata[msc_pkg::ALIGN_ERR_W-1:0]), .value(align_cnt)
  );

  // read mux, narrow registers zero-extended
  wire [msc_pkg::DATA_W-1:0] rd_mux =
      ({32{a_type_id}} & 32'(type_id_q)) |
      ({32{a_uio}} & 32'(uio_q)) |
      ({32{a_pause}} & 32'(pause_cnt)) |
      ({32{a_txg}} & 32'(tx_good_cnt)) |
      ({32{a_one}} & 32'(one_coll_cnt)) |
      ({32{a_many}} & 32'(many_coll_cnt)) |
      ({32{a_rxg}} & 32'(rx_good_cnt)) |
      ({32{a_crc}} & 32'(crc_cnt)) |
      ({32{a_aln}} & 32'(align_cnt));

  // apb answer: no wait states, data and error from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (rd_setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_id_q <= msc_pkg::TYPE_ID_RST;
      uio_q <= msc_pkg::USER_IO_RST;
    end else if (stats_srst) begin
      type_id_q <= msc_pkg::TYPE_ID_RST;
      uio_q <= msc_pkg::USER_IO_RST;
    end else if (wr_access) begin
      if (a_type_id) begin
        type_id_q <= pwdata[msc_pkg::TYPE_ID_W-1:0];
      end
      if (a_uio) begin
        uio_q <= pwdata[msc_pkg::USER_IO_W-1:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rmii_mode = uio_q[msc_pkg::USER_IO_RMII_BIT];
  assign xcvr_clock_gate = uio_q[msc_pkg::USER_IO_CLK_GATE_BIT];
  assign type_id_value = type_id_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || stats_srst);

  sequence pause_read_s;
    rd_setup && a_pause && !inc_pause;
  endsequence
  sequence pause_answer_s;
    (pready && pause_cnt == '0 && prdata == 32'($past(pause_cnt))) ##1 !pready;
  endsequence

  read_clears_a: assert property (
    pause_read_s |=> pause_answer_s
  ) else $error("read did not return value and clear");

  sat_hold_a: assert property (
    (&crc_cnt) && !(psel && a_crc) |=> (&crc_cnt)
  ) else $error("saturated counter moved");

  rx_gate_a: assert property (
    !rx_enable && !psel |=> $stable(rx_good_cnt) && $stable(align_cnt)
  ) else $error("receive counter moved while receive disabled");

  wr_gate_a: assert property (
    wr_access && a_txg && !stats_write_enable && !inc_txg |=> $stable(tx_good_cnt)
  ) else $error("counter write taken while writes disabled");

  pause_inc_a: assert property (
    inc_pause && !(psel && a_pause) && !(&pause_cnt)
    |=> pause_cnt == $past(pause_cnt) + 16'h0001
  ) else $error("pause counter missed a good pause frame");

  tx_ok_inc_a: assert property (
    tx_frame_done && tx_underrun && !(psel && a_txg) |=> $stable(tx_good_cnt)
  ) else $error("underrun frame counted as sent");

  one_coll_a: assert property (
    tx_ok && tx_collisions == 5'h01 && !psel && !(&one_coll_cnt)
    |=> one_coll_cnt == $past(one_coll_cnt) + 16'h0001
  ) else $error("single collision frame not counted");

  many_coll_a: assert property (
    tx_frame_done && tx_collisions == 5'h10 && !psel |=> $stable(many_coll_cnt)
  ) else $error("sixteen collision frame counted");

  rx_good_a: assert property (
    rx_ev && rx_good && !rx_copied && !psel |=> $stable(rx_good_cnt)
  ) else $error("uncopied frame counted as good");

  crc_err_a: assert property (
    rx_ev && rx_whole_bytes && rx_symbol_err && len_ok && !psel && !(&crc_cnt)
    |=> crc_cnt == $past(crc_cnt) + 8'h01
  ) else $error("crc counter missed an error frame");

  align_err_a: assert property (
    rx_ev && !rx_whole_bytes && rx_crc_bad && len_ok && !psel && !(&align_cnt)
    |=> align_cnt == $past(align_cnt) + 8'h01 && $stable(crc_cnt)
  ) else $error("alignment error frame counted wrongly");

  user_io_a: assert property (
    wr_access && a_uio |=> rmii_mode == $past(pwdata[0])
                           && xcvr_clock_gate == $past(pwdata[1])
  ) else $error("user io write not reflected on outputs");

  align_width_a: assert property (
    pready && penable && a_aln && !pwrite |-> prdata[31:8] == 24'h000000
  ) else $error("alignment register upper bits not zero");

  read_race_a: assert property (
    rd_setup && a_crc && inc_crc |=> crc_cnt == 8'h01
  ) else $error("event lost during clearing read");

  sequence apb_answer_s;
    pready ##1 !pready;
  endsequence

  apb_wait_a: assert property (
    setup |=> apb_answer_s
  ) else $error("setup cycle not answered in the next cycle");

  apb_idle_a: assert property (
    !setup |=> !pready && !pslverr
  ) else $error("bus answer without a setup cycle");

  bus_error_a: assert property (
    setup && !mapped |=> pslverr
  ) else $error("unmapped access not flagged");

  unmapped_write_a: assert property (
    wr_access && !mapped |=> $stable(type_id_q) && $stable(uio_q)
  ) else $error("unmapped write changed a register");

  rdata_hold_a: assert property (
    !rd_setup |=> $stable(prdata)
  ) else $error("read data moved without a read");

  type_id_write_a: assert property (
    wr_access && a_type_id |=> type_id_value == $past(pwdata[15:0])
  ) else $error("type id write not reflected on output");

  user_io_hold_a: assert property (
    !(wr_access && a_uio) |=> $stable(rmii_mode) && $stable(xcvr_clock_gate)
  ) else $error("user io outputs moved without a write");

  counter_write_a: assert property (
    wr_access && a_crc && stats_write_enable |=> crc_cnt == $past(pwdata[7:0])
  ) else $error("enabled counter write not taken");

  tx_read_clear_a: assert property (
    rd_setup && a_txg && !inc_txg |=> tx_good_cnt == '0
  ) else $error("transmit counter not cleared by read");

  tx_sat_hold_a: assert property (
    (&tx_good_cnt) && !(psel && a_txg) |=> (&tx_good_cnt)
  ) else $error("saturated transmit counter moved");

  pause_gate_a: assert property (
    rx_frame_done && !rx_enable && !psel |=> $stable(pause_cnt) && $stable(crc_cnt)
  ) else $error("receive event counted while receive disabled");

  one_coll_und_a: assert property (
    tx_frame_done && tx_underrun && !psel |=> $stable(one_coll_cnt)
  ) else $error("underrun frame counted as single collision");

  many_coll_inc_a: assert property (
    tx_frame_done && !tx_underrun && !tx_retry_exceeded && tx_collisions == 5'h0f
    && !psel && !(&many_coll_cnt) |=> many_coll_cnt == $past(many_coll_cnt) + 16'h0001
  ) else $error("fifteen collision frame not counted");

  rx_good_inc_a: assert property (
    rx_frame_done && rx_enable && rx_frame_len == 11'h040 && rx_whole_bytes
    && !rx_crc_bad && !rx_symbol_err && rx_addr_match && rx_copied
    && !psel && !(&rx_good_cnt) |=> rx_good_cnt == $past(rx_good_cnt) + 24'h000001
  ) else $error("good copied frame not counted");

  long_frame_a: assert property (
    rx_frame_done && rx_frame_len > 11'h600 && !psel
    |=> $stable(pause_cnt) && $stable(rx_good_cnt) && $stable(crc_cnt)
  ) else $error("overlong frame counted");

  srst_clear_a: assert property (
    disable iff (!presetn)
    stats_srst |=> type_id_q == msc_pkg::TYPE_ID_RST && uio_q == msc_pkg::USER_IO_RST
                   && rx_good_cnt == '0 && crc_cnt == '0
  ) else $error("synchronous reset left a register set");
endmodule // msc_stats

`default_nettype wire

// >>> verif/msc_mac_model.sv
// frame report source standing in for the mac receive and transmit paths
// assumes one caller at a time; each task gives one pulse then leaves a gap
`timescale 1ns/100ps
`default_nettype none
module msc_mac_model (
  // clock
  input wire logic pclk,
  // receive report
  output logic rx_frame_done,
  output logic [msc_pkg::LEN_W-1:0] rx_frame_len,
  output logic rx_whole_bytes,
  output logic rx_crc_bad,
  output logic rx_symbol_err,
  output logic rx_addr_match,
  output logic rx_copied,
  output logic rx_is_pause,
  // transmit report
  output logic tx_frame_done,
  output logic tx_underrun,
  output logic tx_retry_exceeded,
  output logic [msc_pkg::COLL_W-1:0] tx_collisions
);
  initial begin
    rx_frame_done = 1'b0;
    rx_frame_len = 11'h0;
    {rx_whole_bytes, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied, rx_is_pause} = 6'h0;
    tx_frame_done = 1'b0;
    {tx_underrun, tx_retry_exceeded, tx_collisions} = 7'h0;
  end
  // f is whole, crc bad, symbol error, address match, copied, pause
  task automatic rx(input logic [10:0] len, input logic [5:0] f);
    @(posedge pclk);
    rx_frame_done <= 1'b1;
    rx_frame_len <= len;
    {rx_whole_bytes, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied, rx_is_pause} <= f;
    @(posedge pclk);
    rx_frame_done <= 1'b0;
    // stale fields are scrambled so nothing leans on them
    rx_frame_len <= ~len;
    {rx_whole_bytes, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied, rx_is_pause} <= ~f;
  endtask
  task automatic tx(input logic [4:0] coll, input logic und, input logic rty);
    @(posedge pclk);
    tx_frame_done <= 1'b1;
    {tx_underrun, tx_retry_exceeded, tx_collisions} <= {und, rty, coll};
    @(posedge pclk);
    tx_frame_done <= 1'b0;
    {tx_underrun, tx_retry_exceeded, tx_collisions} <= ~{und, rty, coll};
  endtask
endmodule // msc_mac_model
`default_nettype wire

// >>> verif/msc_stats_test.sv
// self-checking bench of the statistics slice, apb master plus frame source
// assumes the apb slave answers with pready within a few cycles
`timescale 1ns/100ps
`default_nettype none
module msc_stats_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic stats_srst, rx_enable, stats_write_enable, big_frame_enable;
  logic rx_frame_done, rx_whole_bytes, rx_crc_bad, rx_symbol_err;
  logic rx_addr_match, rx_copied, rx_is_pause;
  logic [10:0] rx_frame_len;
  logic tx_frame_done, tx_underrun, tx_retry_exceeded;
  logic [4:0] tx_collisions;
  logic rmii_mode, xcvr_clock_gate;
  logic [15:0] type_id_value;
  int n_mismatch = 0;
  int cmp_count = 0;
  msc_stats dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .stats_srst, .rx_enable, .stats_write_enable, .big_frame_enable,
    .rx_frame_done, .rx_frame_len, .rx_whole_bytes, .rx_crc_bad, .rx_symbol_err,
    .rx_addr_match, .rx_copied, .rx_is_pause, .tx_frame_done, .tx_underrun,
    .tx_retry_exceeded, .tx_collisions, .rmii_mode, .xcvr_clock_gate, .type_id_value);
  msc_mac_model u_mac (.pclk, .rx_frame_done, .rx_frame_len, .rx_whole_bytes,
    .rx_crc_bad, .rx_symbol_err, .rx_addr_match, .rx_copied, .rx_is_pause,
    .tx_frame_done, .tx_underrun, .tx_retry_exceeded, .tx_collisions);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    chk("pslverr", 32'(a > msc_pkg::OFF_ALIGN_ERR || a[1:0] != 2'h0), {31'h0, err_v});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd_v);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err_v});
    chk("unmapped", 32'h0, rd_v);
    apb(1'b1, 8'h24, 32'hffff_ffff);
    chk("pslverr", 32'h1, {31'h0, err_v});
  endtask
  task automatic t_regs;
    wr(msc_pkg::OFF_TYPE_ID, 32'hffff_a5c3);
    rd(msc_pkg::OFF_TYPE_ID, 32'h0000_a5c3);
    chk("type_id", 32'ha5c3, {16'h0, type_id_value});
    for (int i = 0; i < 4; i++) begin
      wr(msc_pkg::OFF_USER_IO, 32'(i));
      rd(msc_pkg::OFF_USER_IO, 32'(i));
      chk("rmii", 32'(i & 1), {31'h0, rmii_mode});
      chk("clk_gate", 32'(i >> 1), {31'h0, xcvr_clock_gate});
    end
  endtask
  task automatic t_rx;
    u_mac.rx(11'h040, 6'h26);
    u_mac.rx(11'h5ee, 6'h27);
    u_mac.rx(11'h5ef, 6'h27);
    u_mac.rx(11'h03f, 6'h27);
    u_mac.rx(11'h040, 6'h24);
    u_mac.rx(11'h064, 6'h36);
    u_mac.rx(11'h5ee, 6'h2e);
    u_mac.rx(11'h5ef, 6'h36);
    u_mac.rx(11'h040, 6'h16);
    u_mac.rx(11'h0c8, 6'h0e);
    rd(msc_pkg::OFF_RX_GOOD, 32'h2);
    rd(msc_pkg::OFF_PAUSE_RX, 32'h1);
    rd(msc_pkg::OFF_CRC_ERR, 32'h2);
    rd(msc_pkg::OFF_ALIGN_ERR, 32'h2);
    rd(msc_pkg::OFF_CRC_ERR, 32'h0);
    @(posedge pclk);
    big_frame_enable <= 1'b1;
    u_mac.rx(11'h600, 6'h27);
    u_mac.rx(11'h601, 6'h36);
    @(posedge pclk);
    rx_enable <= 1'b0;
    u_mac.rx(11'h040, 6'h27);
    rd(msc_pkg::OFF_RX_GOOD, 32'h1);
    rd(msc_pkg::OFF_PAUSE_RX, 32'h1);
    rd(msc_pkg::OFF_CRC_ERR, 32'h0);
    @(posedge pclk);
    rx_enable <= 1'b1;
  endtask
  task automatic t_tx;
    u_mac.tx(5'h00, 1'b0, 1'b0);
    u_mac.tx(5'h01, 1'b0, 1'b0);
    u_mac.tx(5'h02, 1'b0, 1'b0);
    u_mac.tx(5'h0f, 1'b0, 1'b0);
    u_mac.tx(5'h10, 1'b0, 1'b1);
    u_mac.tx(5'h01, 1'b1, 1'b0);
    rd(msc_pkg::OFF_TX_GOOD, 32'h4);
    rd(msc_pkg::OFF_ONE_COLL, 32'h1);
    rd(msc_pkg::OFF_MANY_COLL, 32'h2);
  endtask
  task automatic t_wr_sat;
    wr(msc_pkg::OFF_CRC_ERR, 32'h5);
    rd(msc_pkg::OFF_CRC_ERR, 32'h0);
    wr(msc_pkg::OFF_TX_GOOD, 32'h9);
    rd(msc_pkg::OFF_TX_GOOD, 32'h0);
    @(posedge pclk);
    stats_write_enable <= 1'b1;
    wr(msc_pkg::OFF_CRC_ERR, 32'hff);
    u_mac.rx(11'h064, 6'h36);
    rd(msc_pkg::OFF_CRC_ERR, 32'hff);
    rd(msc_pkg::OFF_CRC_ERR, 32'h0);
    wr(msc_pkg::OFF_TX_GOOD, 32'hff_ffff);
    u_mac.tx(5'h00, 1'b0, 1'b0);
    rd(msc_pkg::OFF_TX_GOOD, 32'hff_ffff);
    wr(msc_pkg::OFF_CRC_ERR, 32'h3);
    fork
      rd(msc_pkg::OFF_CRC_ERR, 32'h3);
      u_mac.rx(11'h064, 6'h36);
    join
    rd(msc_pkg::OFF_CRC_ERR, 32'h1);
  endtask
  task automatic t_srst;
    wr(msc_pkg::OFF_TYPE_ID, 32'h1234);
    wr(msc_pkg::OFF_USER_IO, 32'h3);
    wr(msc_pkg::OFF_RX_GOOD, 32'h7);
    @(posedge pclk);
    stats_srst <= 1'b1;
    @(posedge pclk);
    stats_srst <= 1'b0;
    rd(msc_pkg::OFF_TYPE_ID, 32'h0);
    rd(msc_pkg::OFF_USER_IO, 32'h0);
    rd(msc_pkg::OFF_RX_GOOD, 32'h0);
    chk("clk_gate", 32'h0, {31'h0, xcvr_clock_gate});
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {stats_srst, stats_write_enable, big_frame_enable} = 3'h0;
    rx_enable = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_rx;
    t_tx;
    t_wr_sat;
    t_srst;
    tally_and_finish;
  end
endmodule // msc_stats_test
`default_nettype wire
